// ---- shared/child_dec_params.svh ----
`ifndef CHILD_DEC_PARAMS_SVH
`define CHILD_DEC_PARAMS_SVH
// leaf index of this operation
`define LEAF_DEC_CHILD 32'h0000_0000
// capability bit reporting availability
`define CAP_BIT_POS 5
// page offset mask for 4K alignment
`define PAGE_OFS_MASK 64'h0000_0000_0000_0FFF
// required privilege level
`define PRIV_KERNEL 2'h0
// result codes in the accumulator (values chosen here)
`define RES_OK 64'h0000_0000_0000_0000
`define RES_PAGE_CONFLICT 64'h0000_0000_0000_0009
`define RES_INVALID_COUNTER 64'h0000_0000_0000_0038
// fault kinds
`define FAULT_NONE 2'h0
`define FAULT_GP 2'h1
`define FAULT_PF 2'h2
`define FAULT_UD 2'h3
// page fault error code bit for enclave faults
`define PFEC_ENCLAVE_BIT 15
// page map access ports: 0 target, 1 control structure
`define PORT_TGT 1'b0
`define PORT_CS 1'b1
// wishbone register byte addresses
`define ADR_STATUS 4'h0
`define ADR_MASK 4'h4
`define ADR_CAP 4'h8
`define ADR_COUNT 4'hC
// interrupt status bits
`define IRQ_DONE 0
`define IRQ_FAULT 1
`define IRQ_ERR 2
`endif

// ---- shared/child_dec_pkg.sv ----
package child_dec_pkg;
  typedef enum logic [2:0] {
    REGULAR_PAGE_TYPE_T = 3'h0,
    THREAD_CONTROL_PAGE_TYPE_T = 3'h1,
    TRIMMED_PAGE_TYPE_T = 3'h2,
    CONTROL_STRUCTURE_PAGE_TYPE_T = 3'h3,
    FIRST_SHADOW_STACK_PAGE_TYPE_T = 3'h4,
    LATER_SHADOW_STACK_PAGE_TYPE_T = 3'h5,
    PT_OTHER_T = 3'h7
  } page_type_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_XLATE = 5'b00010,
    ST_MAP = 5'b00100,
    ST_ATOMIC = 5'b01000,
    ST_DONE = 5'b10000
  } state_t;
endpackage

// ---- rtl/child_dec_leaf.sv ----
// Our own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "child_dec_params.svh"
// Functional notes
// - leaf index zero selects decrement; capability bit
// - only privilege level zero may execute
// - addresses formed from data segment only
// - unaligned target pointer gives protection fault
// - target outside page cache: enclave page fault
// - control pointer outside cache: enclave page fault
// - busy target: zero flag, conflict code
// - invalid target page: enclave page fault
// - owner derived from page type
// - owner mismatch gives protection fault zero
// - atomic decrement, underflow restores, invalid code
// - counter is unsigned 64 bit
// - success clears zero flag, accumulator zero
// - non-faulting exits clear five arithmetic flags
// - 32-bit: limit or unusable segment faults
// - 64-bit: non-canonical address faults
// - target rw non-enclave; control read enclave
module child_dec_leaf #(
  parameter int ADDR_W = 64,
  parameter int CNT_W = 64
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // operation request from the core
  input wire logic start_i,
  input wire logic [31:0] leaf_index_register_i,
  input wire logic [ADDR_W-1:0] target_page_pointer_i,
  input wire logic [ADDR_W-1:0] control_structure_pointer_i,
  input wire logic [1:0] cpl_i,
  input wire logic mode64_i,
  input wire logic [ADDR_W-1:0] data_segment_base_i,
  input wire logic [31:0] data_segment_limit_i,
  input wire logic data_segment_unusable_i,
  // result to the core
  output logic done_o,
  output logic [1:0] fault_kind_o,
  output logic [31:0] fault_code_o,
  output logic [ADDR_W-1:0] fault_addr_o,
  output logic [ADDR_W-1:0] accumulator_result_o,
  output logic zero_flag_o,
  output logic arith_flags_clear_o,
  // address translation and page map lookup
  output logic map_req_o,
  output logic map_port_o,
  output logic [ADDR_W-1:0] map_lin_addr_o,
  output logic map_write_perm_o,
  output logic map_enclave_ctx_o,
  input wire logic map_ack_i,
  input wire logic map_in_cache_i,
  input wire logic [ADDR_W-1:0] map_phys_i,
  input wire logic map_valid_i,
  input wire logic map_busy_i,
  input wire child_dec_pkg::page_type_t map_type_i,
  input wire logic [ADDR_W-1:0] map_owner_i,
  // locked counter access
  output logic cnt_req_o,
  output logic [ADDR_W-1:0] cnt_addr_o,
  output logic cnt_dec_o,
  input wire logic cnt_ack_i,
  input wire logic [CNT_W-1:0] cnt_old_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // interrupt
  output logic irq_o
);
  import child_dec_pkg::*;

  typedef struct packed {
    state_t st;
    logic port;
    logic [ADDR_W-1:0] tgt_lin;
    logic [ADDR_W-1:0] cs_lin;
    logic [ADDR_W-1:0] tgt_phys;
    logic [ADDR_W-1:0] cs_phys;
    logic [ADDR_W-1:0] owner;
    logic restore;
    logic done;
    logic [1:0] fkind;
    logic [31:0] fcode;
    logic [ADDR_W-1:0] faddr;
    logic [ADDR_W-1:0] acc;
    logic zf;
    logic aclr;
    logic map_req;
    logic cnt_req;
    logic cnt_dec;
    logic [2:0] sts;
    logic [2:0] msk;
    logic [31:0] ops;
    logic cap_en;
    logic [31:0] rdat;
    logic ack;
    logic irq;
  } regs_t;

  regs_t cur_reg, cur_next;

  // canonical check for 48-bit virtual addresses
  function automatic logic canon(input logic [ADDR_W-1:0] a);
    canon = (a[ADDR_W-1:47] == '0) || (a[ADDR_W-1:47] == '1);
  endfunction

  // segment limit check in 32-bit mode on the effective address
  function automatic logic seg_bad(input logic [ADDR_W-1:0] ea);
    seg_bad = data_segment_unusable_i ||
              (ea[ADDR_W-1:32] != '0) ||
              (ea[31:0] > data_segment_limit_i);
  endfunction

  logic [ADDR_W-1:0] tgt_lin, cs_lin;
  logic addr_fault;
  logic wb_hit;

  always_comb begin
    tgt_lin = data_segment_base_i + target_page_pointer_i;
    cs_lin = data_segment_base_i + control_structure_pointer_i;
    if (mode64_i) begin
      addr_fault = !canon(tgt_lin) || !canon(cs_lin);
    end else begin
      addr_fault = seg_bad(target_page_pointer_i) ||
                   seg_bad(control_structure_pointer_i);
    end
    wb_hit = wb_cyc_i && wb_stb_i && !cur_reg.ack;
  end

  always_comb begin
    cur_next = cur_reg;
    cur_next.done = 1'b0;
    cur_next.ack = 1'b0;
    case (cur_reg.st)
      ST_IDLE: begin
        if (start_i) begin
          cur_next.tgt_lin = tgt_lin;
          cur_next.cs_lin = cs_lin;
          cur_next.fkind = `FAULT_NONE;
          cur_next.fcode = '0;
          cur_next.faddr = '0;
          cur_next.aclr = 1'b0;
          cur_next.restore = 1'b0;
          // only leaf zero, and only when available
          if (leaf_index_register_i != `LEAF_DEC_CHILD ||
              !cur_reg.cap_en) begin
            cur_next.fkind = `FAULT_UD;
            cur_next.st = ST_DONE;
          end else if (cpl_i != `PRIV_KERNEL) begin
            cur_next.fkind = `FAULT_GP;
            cur_next.st = ST_DONE;
          end else if (addr_fault) begin
            cur_next.fkind = `FAULT_GP;
            cur_next.st = ST_DONE;
          end else if ((target_page_pointer_i & `PAGE_OFS_MASK) != '0)
          begin
            cur_next.fkind = `FAULT_GP;
            cur_next.st = ST_DONE;
          end else begin
            cur_next.port = `PORT_TGT;
            cur_next.map_req = 1'b1;
            cur_next.st = ST_XLATE;
          end
        end
      end
      ST_XLATE: begin
        if (map_ack_i) begin
          cur_next.map_req = 1'b0;
          if (!map_in_cache_i) begin
            // enclave page fault on resolve miss
            cur_next.fkind = `FAULT_PF;
            cur_next.fcode = 32'h1 << `PFEC_ENCLAVE_BIT;
            cur_next.faddr = (cur_reg.port == `PORT_TGT) ?
                             cur_reg.tgt_lin : cur_reg.cs_lin;
            cur_next.st = ST_DONE;
          end else if (cur_reg.port == `PORT_TGT) begin
            cur_next.tgt_phys = map_phys_i;
            cur_next.port = `PORT_CS;
            cur_next.map_req = 1'b1;
          end else begin
            cur_next.cs_phys = map_phys_i;
            cur_next.port = `PORT_TGT;
            cur_next.map_req = 1'b1;
            cur_next.st = ST_MAP;
          end
        end
      end
      ST_MAP: begin
        if (map_ack_i) begin
          cur_next.map_req = 1'b0;
          cur_next.st = ST_DONE;
          if (map_busy_i) begin
            cur_next.zf = 1'b1;
            cur_next.acc = `RES_PAGE_CONFLICT;
            cur_next.aclr = 1'b1;
          end else if (!map_valid_i) begin
            cur_next.fkind = `FAULT_PF;
            cur_next.fcode = 32'h1 << `PFEC_ENCLAVE_BIT;
            cur_next.faddr = cur_reg.tgt_lin;
          end else begin
            case (map_type_i)
              REGULAR_PAGE_TYPE_T, THREAD_CONTROL_PAGE_TYPE_T, TRIMMED_PAGE_TYPE_T,
              FIRST_SHADOW_STACK_PAGE_TYPE_T, LATER_SHADOW_STACK_PAGE_TYPE_T: cur_next.owner = map_owner_i;
              CONTROL_STRUCTURE_PAGE_TYPE_T: cur_next.owner = cur_reg.tgt_phys;
              default: begin
                cur_next.fkind = `FAULT_PF;
                cur_next.fcode = 32'h1 << `PFEC_ENCLAVE_BIT;
                cur_next.faddr = cur_reg.tgt_lin;
              end
            endcase
            if (map_type_i inside {REGULAR_PAGE_TYPE_T, THREAD_CONTROL_PAGE_TYPE_T, TRIMMED_PAGE_TYPE_T,
                FIRST_SHADOW_STACK_PAGE_TYPE_T, LATER_SHADOW_STACK_PAGE_TYPE_T, CONTROL_STRUCTURE_PAGE_TYPE_T}) begin
              if (((map_type_i == CONTROL_STRUCTURE_PAGE_TYPE_T) ? cur_reg.tgt_phys :
                   map_owner_i) != cur_reg.cs_phys) begin
                cur_next.fkind = `FAULT_GP;
              end else begin
                cur_next.cnt_req = 1'b1;
                cur_next.cnt_dec = 1'b1;
                cur_next.st = ST_ATOMIC;
              end
            end
          end
        end
      end
      ST_ATOMIC: begin
        if (cnt_ack_i) begin
          cur_next.cnt_req = 1'b0;
          if (cur_reg.restore) begin
            cur_next.st = ST_DONE;
          // unsigned underflow: old value was zero
          end else if (cnt_old_i == '0) begin
            cur_next.restore = 1'b1;
            cur_next.cnt_dec = 1'b0;
            cur_next.cnt_req = 1'b1;
            cur_next.zf = 1'b1;
            cur_next.acc = `RES_INVALID_COUNTER;
            cur_next.aclr = 1'b1;
          end else begin
            cur_next.zf = 1'b0;
            cur_next.acc = `RES_OK;
            cur_next.aclr = 1'b1;
            cur_next.st = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        // flags cleared on every non-faulting exit via aclr
        cur_next.done = 1'b1;
        cur_next.ops = cur_reg.ops + 32'h1;
        cur_next.sts[`IRQ_DONE] = 1'b1;
        if (cur_reg.fkind != `FAULT_NONE) begin
          cur_next.sts[`IRQ_FAULT] = 1'b1;
        end
        if (cur_reg.zf && cur_reg.fkind == `FAULT_NONE) begin
          cur_next.sts[`IRQ_ERR] = 1'b1;
        end
        cur_next.st = ST_IDLE;
      end
      default: cur_next.st = ST_IDLE;
    endcase

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    if (wb_hit) begin
      cur_next.ack = 1'b1;
      cur_next.rdat = '0;
      case (wb_adr_i)
        `ADR_STATUS: begin
          cur_next.rdat = {29'h0, cur_reg.sts};
          // write one to clear; a new event in this cycle wins
          if (wb_we_i && wb_sel_i[0]) begin
            cur_next.sts = cur_next.sts &
              ~(wb_dat_i[2:0] & ~(cur_next.sts & ~cur_reg.sts));
          end
        end
        `ADR_MASK: begin
          cur_next.rdat = {29'h0, cur_reg.msk};
          if (wb_we_i && wb_sel_i[0]) begin
            cur_next.msk = wb_dat_i[2:0];
          end
        end
        `ADR_CAP: begin
          cur_next.rdat = 32'(cur_reg.cap_en) << `CAP_BIT_POS;
          if (wb_we_i && wb_sel_i[0]) begin
            cur_next.cap_en = wb_dat_i[`CAP_BIT_POS];
          end
        end
        `ADR_COUNT: cur_next.rdat = cur_reg.ops;
        default: cur_next.rdat = '0;
      endcase
    end
    cur_next.irq = |(cur_next.sts & cur_next.msk);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_reg <= '0;
      cur_reg.st <= ST_IDLE;
      cur_reg.cap_en <= 1'b1;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign done_o = cur_reg.done;
  assign fault_kind_o = cur_reg.fkind;
  assign fault_code_o = cur_reg.fcode;
  assign fault_addr_o = cur_reg.faddr;
  assign accumulator_result_o = cur_reg.acc;
  assign zero_flag_o = cur_reg.zf;
  assign arith_flags_clear_o = cur_reg.aclr;
  assign map_req_o = cur_reg.map_req;
  assign map_port_o = cur_reg.port;
  assign map_lin_addr_o = (cur_reg.port == `PORT_TGT) ?
                          cur_reg.tgt_lin : cur_reg.cs_lin;
  // target rw from non-enclave, control read as enclave
  assign map_write_perm_o = (cur_reg.port == `PORT_TGT);
  assign map_enclave_ctx_o = (cur_reg.port == `PORT_CS);
  assign cnt_req_o = cur_reg.cnt_req;
  assign cnt_addr_o = cur_reg.owner;
  assign cnt_dec_o = cur_reg.cnt_dec;
  assign wb_dat_o = cur_reg.rdat;
  assign wb_ack_o = cur_reg.ack;
  assign irq_o = cur_reg.irq;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_start_priv;
    start_i && cur_reg.st == ST_IDLE && cpl_i != `PRIV_KERNEL;
  endsequence

  a_priv_refuse: assert property (@(posedge clk_i) disable iff (rst_i)
    s_start_priv |=> ##1 (done_o && fault_kind_o != `FAULT_NONE))
    else $error("privilege not refused");
  a_align_fault: assert property (@(posedge clk_i) disable iff (rst_i)
    (start_i && cur_reg.st == ST_IDLE && cpl_i == `PRIV_KERNEL &&
     leaf_index_register_i == `LEAF_DEC_CHILD && cur_reg.cap_en &&
     !addr_fault && target_page_pointer_i[11:0] != 12'h0)
    |=> ##1 (done_o && fault_kind_o == `FAULT_GP))
    else $error("misaligned target not faulted");
  a_miss_pf: assert property (@(posedge clk_i) disable iff (rst_i)
    (cur_reg.st == ST_XLATE && map_ack_i && !map_in_cache_i)
    |=> ##1 (done_o && fault_kind_o == `FAULT_PF &&
             fault_code_o[`PFEC_ENCLAVE_BIT]))
    else $error("resolve miss not page fault");
  a_conflict_exit: assert property (@(posedge clk_i) disable iff (rst_i)
    (cur_reg.st == ST_MAP && map_ack_i && map_busy_i)
    |=> ##1 (done_o && zero_flag_o &&
             accumulator_result_o == `RES_PAGE_CONFLICT))
    else $error("conflict exit wrong");
  a_invalid_pf: assert property (@(posedge clk_i) disable iff (rst_i)
    (cur_reg.st == ST_MAP && map_ack_i && !map_busy_i && !map_valid_i)
    |=> ##1 (done_o && fault_kind_o == `FAULT_PF))
    else $error("invalid page not faulted");
  a_owner_gp: assert property (@(posedge clk_i) disable iff (rst_i)
    (cur_reg.st == ST_MAP && map_ack_i && !map_busy_i && map_valid_i &&
     map_type_i == REGULAR_PAGE_TYPE_T && map_owner_i != cur_reg.cs_phys)
    |=> ##1 (done_o && fault_kind_o == `FAULT_GP))
    else $error("owner mismatch not faulted");
  a_underflow_fix: assert property (@(posedge clk_i) disable iff (rst_i)
    (cur_reg.st == ST_ATOMIC && cnt_ack_i && !cur_reg.restore &&
     cnt_old_i == '0)
    |=> (cnt_req_o && !cnt_dec_o && zero_flag_o &&
         accumulator_result_o == `RES_INVALID_COUNTER))
    else $error("underflow not restored");
  a_success_ok: assert property (@(posedge clk_i) disable iff (rst_i)
    (done_o && fault_kind_o == `FAULT_NONE && !zero_flag_o)
    |-> accumulator_result_o == `RES_OK && arith_flags_clear_o)
    else $error("success result wrong");
  a_flags_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (done_o && fault_kind_o == `FAULT_NONE) |-> arith_flags_clear_o)
    else $error("flags not cleared");
endmodule

// ---- testbench/child_counter_decrement_leaf_test.sv ----
`timescale 1ns/1ps
`include "child_dec_params.svh"
module child_counter_decrement_leaf_test;
  import child_dec_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic start = 1'b0, mode64 = 1'b1, unus = 1'b0, mack = 1'b0;
  logic min = 1'b0, mvalid = 1'b0, mbusy = 1'b0, cack = 1'b0;
  logic wcyc = 1'b0, wstb = 1'b0, wwe = 1'b0;
  logic [31:0] leaf = 32'h0, lim = 32'hFFFF_FFFF, wdat = 32'h0, rdat;
  logic [1:0] cpl = 2'h0;
  logic [63:0] tptr = 64'h0, cptr = 64'h0, base = 64'h0;
  logic [63:0] mphys = 64'h0, mowner = 64'h0, cold = 64'h0;
  logic [3:0] wadr = 4'h0, wsel = 4'h0;
  page_type_t mtype = REGULAR_PAGE_TYPE_T;
  logic done, zf, aclr, mreq, mport, mwp, mec, creq, cdec, wack, irq;
  logic [1:0] fkind;
  logic [31:0] fcode, wdo;
  logic [63:0] faddr, acc, mlin, caddr;
  logic tin, cin, busy, vld;
  page_type_t ptyp;
  logic [63:0] tphys, cphys, mown_v, eown, cnt, lin0;
  int slow, dly, nmap, ncnt, error_cnt = 0, checks_done = 0;

  always #2 clk_i = ~clk_i;

  child_dec_leaf u_child_dec_leaf (.clk_i(clk_i), .rst_i(rst_i),
    .start_i(start), .leaf_index_register_i(leaf),
    .target_page_pointer_i(tptr), .control_structure_pointer_i(cptr),
    .cpl_i(cpl), .mode64_i(mode64), .data_segment_base_i(base),
    .data_segment_limit_i(lim), .data_segment_unusable_i(unus),
    .done_o(done), .fault_kind_o(fkind), .fault_code_o(fcode),
    .fault_addr_o(faddr), .accumulator_result_o(acc), .zero_flag_o(zf),
    .arith_flags_clear_o(aclr), .map_req_o(mreq), .map_port_o(mport),
    .map_lin_addr_o(mlin), .map_write_perm_o(mwp),
    .map_enclave_ctx_o(mec), .map_ack_i(mack), .map_in_cache_i(min),
    .map_phys_i(mphys), .map_valid_i(mvalid), .map_busy_i(mbusy),
    .map_type_i(mtype), .map_owner_i(mowner), .cnt_req_o(creq),
    .cnt_addr_o(caddr), .cnt_dec_o(cdec), .cnt_ack_i(cack),
    .cnt_old_i(cold), .wb_cyc_i(wcyc), .wb_stb_i(wstb), .wb_we_i(wwe),
    .wb_adr_i(wadr), .wb_sel_i(wsel), .wb_dat_i(wdat), .wb_dat_o(wdo),
    .wb_ack_o(wack), .irq_o(irq));

  task automatic chk(input string nm, input logic [63:0] e, g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task stop_test;
    if (error_cnt == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // far-side responders
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    mack <= 1'b0;
    if (mreq === 1'b1 && !mack) begin
      if (dly < slow) dly++;
      else begin
        dly = 0;
        if (nmap == 0) lin0 = mlin;
        nmap++;
        // access permission per operand
        chk("map_perm", 1'b1, mport ? mec : mwp);
        mack <= 1'b1;
        min <= mport ? cin : tin;
        mphys <= mport ? cphys : tphys;
        mvalid <= vld;
        mbusy <= busy;
        mtype <= ptyp;
        mowner <= mown_v;
      end
    end
  end

  always @(posedge clk_i) begin
    cack <= 1'b0;
    if (creq === 1'b1 && !cack) begin
      ncnt++;
      chk("cnt_addr", eown, caddr);
      cack <= 1'b1;
      cold <= cnt;
      cnt = cdec ? cnt - 64'h1 : cnt + 64'h1;
    end
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic dflt;
    tin = 1; cin = 1; busy = 0; vld = 1; slow = 0; dly = 0;
    ptyp = REGULAR_PAGE_TYPE_T;
    tphys = 64'h0000_0000_0050_0000;
    cphys = 64'h0000_0000_0060_0000;
    mown_v = cphys; eown = cphys;
    cpl <= 2'h0; mode64 <= 1'b1; base <= 64'h0; unus <= 1'b0;
    lim <= 32'hFFFF_FFFF;
  endtask

  task automatic run_op(input logic [31:0] lf, input logic [63:0] tp, cp);
    int n;
    nmap = 0;
    ncnt = 0;
    @(posedge clk_i);
    start <= 1'b1; leaf <= lf; tptr <= tp; cptr <= cp;
    @(posedge clk_i);
    start <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 300) chk("done", 1'b1, done);
  endtask

  task automatic res(input logic [1:0] k, input logic [63:0] a,
                     input logic z);
    chk("fault_kind", {62'h0, k}, {62'h0, fkind});
    if (k === `FAULT_NONE) begin
      chk("accumulator", a, acc);
      chk("zero_flag", {63'h0, z}, {63'h0, zf});
      chk("flags_clear", 64'h1, {63'h0, aclr});
    end
  endtask

  task automatic pf(input logic [63:0] ad);
    res(`FAULT_PF, 64'h0, 1'b0);
    chk("pf_bit", 64'h1, {63'h0, fcode[`PFEC_ENCLAVE_BIT]});
    chk("fault_addr", ad, faddr);
  endtask

  task automatic gp;
    res(`FAULT_GP, 64'h0, 1'b0);
    chk("gp_code", 64'h0, {32'h0, fcode});
  endtask

  task automatic wb(input logic w, input logic [3:0] a, s,
                    input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wcyc <= 1'b1; wstb <= 1'b1; wwe <= w; wadr <= a; wsel <= s;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wack !== 1'b1 && n < 50);
    if (n >= 50) chk("wb_ack", 64'h1, {63'h0, wack});
    rdat = wdo;
    wcyc <= 1'b0; wstb <= 1'b0;
    @(posedge clk_i);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  localparam logic [63:0] TP = 64'h0000_0000_1234_5000;
  localparam logic [63:0] CP = 64'h0000_0000_0ABC_D000;

  task automatic t_success;
    dflt; slow = 3; cnt = 64'h8000_0000_0000_0000;
    run_op(`LEAF_DEC_CHILD, TP, CP);
    res(`FAULT_NONE, `RES_OK, 1'b0);
    chk("counter", 64'h7FFF_FFFF_FFFF_FFFF, cnt);
    chk("map_count", 64'h3, nmap);
  endtask

  task automatic t_types;
    page_type_t ok_t[6] = '{REGULAR_PAGE_TYPE_T, THREAD_CONTROL_PAGE_TYPE_T, TRIMMED_PAGE_TYPE_T, FIRST_SHADOW_STACK_PAGE_TYPE_T,
                            LATER_SHADOW_STACK_PAGE_TYPE_T, CONTROL_STRUCTURE_PAGE_TYPE_T};
    foreach (ok_t[i]) begin
      dflt; cnt = 64'h5; ptyp = ok_t[i];
      if (ok_t[i] == CONTROL_STRUCTURE_PAGE_TYPE_T) begin
        tphys = cphys; mown_v = 64'h0000_0000_0070_0000;
      end
      run_op(`LEAF_DEC_CHILD, TP, CP);
      res(`FAULT_NONE, `RES_OK, 1'b0);
      chk("counter", 64'h4, cnt);
    end
    dflt; ptyp = PT_OTHER_T;
    run_op(`LEAF_DEC_CHILD, TP, CP);
    pf(TP);
    dflt; mown_v = 64'h0000_0000_0070_0000;
    run_op(`LEAF_DEC_CHILD, TP, CP);
    gp;
    chk("cnt_requests", 64'h0, ncnt);
  endtask

  task automatic t_underflow;
    dflt; cnt = 64'h0; slow = 1;
    run_op(`LEAF_DEC_CHILD, TP, CP);
    res(`FAULT_NONE, `RES_INVALID_COUNTER, 1'b1);
    chk("counter", 64'h0, cnt);
    chk("cnt_requests", 64'h2, ncnt);
  endtask

  task automatic t_conflict;
    dflt; busy = 1; vld = 0; cnt = 64'h3;
    run_op(`LEAF_DEC_CHILD, TP, CP);
    res(`FAULT_NONE, `RES_PAGE_CONFLICT, 1'b1);
    chk("counter", 64'h3, cnt);
    dflt; vld = 0;
    run_op(`LEAF_DEC_CHILD, TP, CP);
    pf(TP);
  endtask

  task automatic t_faults;
    dflt; tin = 0;
    run_op(`LEAF_DEC_CHILD, TP | 64'h8, CP);
    gp;
    chk("map_count", 64'h0, nmap);
    dflt; tin = 0; cin = 0;
    run_op(`LEAF_DEC_CHILD, TP, CP);
    pf(TP);
    dflt; cin = 0;
    run_op(`LEAF_DEC_CHILD, TP, CP);
    pf(CP);
  endtask

  task automatic t_modes;
    dflt;
    run_op(`LEAF_DEC_CHILD, 64'h0001_0000_0000_0000, CP);
    gp;
    dflt;
    @(posedge clk_i);
    mode64 <= 1'b0; base <= 64'h1000; lim <= 32'hFFFF; cnt = 64'h2;
    run_op(`LEAF_DEC_CHILD, 64'h2000, 64'h3000);
    res(`FAULT_NONE, `RES_OK, 1'b0);
    chk("linear_addr", 64'h3000, lin0);
    run_op(`LEAF_DEC_CHILD, 64'h20000, 64'h3000);
    gp;
    unus <= 1'b1;
    run_op(`LEAF_DEC_CHILD, 64'h2000, 64'h3000);
    gp;
    dflt;
    @(posedge clk_i);
    cpl <= 2'h3;
    run_op(`LEAF_DEC_CHILD, TP, CP);
    res(`FAULT_GP, 64'h0, 1'b0);
    chk("map_count", 64'h0, nmap);
    dflt;
    run_op(32'h1, TP, CP);
    res(`FAULT_UD, 64'h0, 1'b0);
  endtask

  task automatic t_regs;
    logic [31:0] c0;
    wb(1'b0, `ADR_CAP, 4'hF, 32'h0);
    chk("cap_enable", 64'h1, {63'h0, rdat[`CAP_BIT_POS]});
    wb(1'b1, `ADR_STATUS, 4'hF, 32'h7);
    wb(1'b1, `ADR_MASK, 4'hF, 32'h0);
    wb(1'b0, `ADR_COUNT, 4'hF, 32'h0);
    c0 = rdat;
    dflt; cnt = 64'h9;
    run_op(`LEAF_DEC_CHILD, TP, CP);
    wb(1'b1, `ADR_COUNT, 4'hF, 32'h0);
    wb(1'b0, `ADR_COUNT, 4'hF, 32'h0);
    chk("op_count", {32'h0, c0 + 32'h1}, {32'h0, rdat});
    chk("irq_masked", 64'h0, {63'h0, irq});
    wb(1'b0, `ADR_STATUS, 4'hF, 32'h0);
    chk("status_done", 64'h1, {63'h0, rdat[`IRQ_DONE]});
    wb(1'b1, `ADR_MASK, 4'hF, 32'h7);
    @(posedge clk_i);
    chk("irq_open", 64'h1, {63'h0, irq});
    wb(1'b1, `ADR_STATUS, 4'hF, 32'h7);
    @(posedge clk_i);
    chk("irq_clear", 64'h0, {63'h0, irq});
    wb(1'b1, `ADR_CAP, 4'h0, 32'h0);
    run_op(`LEAF_DEC_CHILD, TP, CP);
    res(`FAULT_NONE, `RES_OK, 1'b0);
    wb(1'b1, `ADR_CAP, 4'hF, 32'h0);
    run_op(`LEAF_DEC_CHILD, TP, CP);
    res(`FAULT_UD, 64'h0, 1'b0);
    wb(1'b1, `ADR_CAP, 4'hF, 32'h20);
  endtask

  initial begin
    #(4 * 20000);
    error_cnt++;
    stop_test;
  end

  initial begin
    dflt;
    cnt = 64'h0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("reset_done", 64'h0, {63'h0, done});
    t_success;
    t_types;
    t_underflow;
    t_conflict;
    t_faults;
    t_modes;
    t_regs;
    stop_test;
  end
endmodule
